// *** rtl/shift_bitfield_satmul_pkg.sv ***
`default_nettype none
package shift_bitfield_satmul_pkg;

    // Data widths
    localparam int W_WORD = 32;
    localparam int W_LONG = 40;
    localparam int W_HALF = 16;

    // Bit-field control operand layout
    localparam int SETF_END_LSB   = 0;
    localparam int SETF_START_LSB = 5;
    localparam int SETF_POS_W     = 5;

    // Shift operation field: bit 0 register form, bit 1 word source, bit 5 signed source
    localparam int OPF_REG_BIT    = 0;
    localparam int OPF_WORD_BIT   = 1;
    localparam int OPF_SIGNED_BIT = 5;

    // Shift operation field codes, register forms
    localparam logic [5:0] OPF_ALS_WORD  = 6'h33;
    localparam logic [5:0] OPF_ALS_LONG  = 6'h31;
    localparam logic [5:0] OPF_ALS_UWORD = 6'h13;
    localparam logic [5:0] OPF_ARS_WORD  = 6'h37;
    localparam logic [5:0] OPF_ARS_LONG  = 6'h35;
    localparam logic [5:0] OPF_LRS_WORD  = 6'h27;
    localparam logic [5:0] OPF_LRS_LONG  = 6'h25;

    // Shift amount limits
    localparam logic [5:0] SHAMT_MAX_VALID = 6'h27;
    localparam logic [5:0] SHAMT_LIMIT     = 6'h28;

    // Fractional multiply and clamp values
    localparam logic [31:0] FRAC_NEG_ONE = 32'h8000_0000;
    localparam logic [31:0] WORD_MAX     = 32'h7FFF_FFFF;
    localparam logic [31:0] WORD_MIN     = 32'h8000_0000;
    localparam logic [39:0] LONG_WORD_MAX = 40'h00_7FFF_FFFF;
    localparam logic [39:0] LONG_WORD_MIN = 40'hFF_8000_0000;

    // Reset values
    localparam logic FLAG_RESET = 1'b0;

    typedef enum logic [6:0] {
        op_bit_set             = 7'h01,
        arith_left_shift_op    = 7'h02,
        arith_right_shift_op   = 7'h04,
        logical_right_shift_op = 7'h08,
        frac_mul_low_low_op    = 7'h10,
        frac_mul_high_high_op  = 7'h20,
        op_clamp_40_to_32      = 7'h40
    } unit_op_t;

    typedef struct packed {
        logic        valid;
        unit_op_t    op;
        logic [5:0]  opfield;
        logic        cst_form;
        logic [4:0]  csta;
        logic [4:0]  cstb;
        logic [31:0] src1;
        logic [39:0] src2;
    } exec_req_t;

    typedef struct packed {
        logic        valid;
        logic        pair;
        logic        clamped;
        logic [31:0] lo;
        logic [31:0] hi;
    } exec_res_t;

    typedef struct packed {
        exec_res_t   s_res;
        logic        m_valid;
        logic [31:0] m_prod;
        exec_res_t   m_res;
        logic        saturation_flag;
    } unit_state_t;

endpackage
`default_nettype wire

// *** rtl/shift_bitfield_satmul_unit.sv ***
`default_nettype none
// Operation
// - Set field bits to one, rest pass
// - Bit positions zero at LSB to 31
// - Register form: end bits 0-4, start 5-9
// - Left shift: word, long, unsigned-to-long forms
// - Register amount six bits, immediate five bits
// - Left shift amounts 40..63 shift by 40
// - Amount bits above bit 5 ignored
// - Arithmetic right shift sign fills, clamps 40
// - Logical right shift zero fills, clamps 40
// - Low halves multiplied, product shifted left one
// - High halves multiplied, product shifted left one
// - Multiply halves are signed two's complement
// - Shifted product 8000_0000 becomes 7FFF_FFFF
// - Flag sets one cycle after clamped write
// - Multiply result after one delay slot
// - Long-to-word conversion clamps to extremes
module shift_bitfield_satmul_unit
    import shift_bitfield_satmul_pkg::*;
(
    // Clock and reset
    input  wire logic      core_clk,
    input  wire logic      rst_n,
    // Issue from decode
    input  wire exec_req_t req,
    // Flag clear from control status write
    input  wire logic      flag_clear,
    // Results to register file
    output var  exec_res_t s_res,
    output var  exec_res_t m_res,
    // Sticky flag in control status
    output logic           saturation_flag
);

    unit_state_t st_r;
    unit_state_t st_nxt;

    logic [4:0]  set_start;
    logic [4:0]  set_end;
    logic [31:0] set_mask;
    logic [5:0]  amt_reg;
    logic [5:0]  amt;
    logic        src_signed;
    logic        src_word;
    logic [39:0] src_x;
    logic [39:0] shl_v;
    logic [39:0] shr_v;
    logic [39:0] logical_right_shift_op_v;
    logic [39:0] sh_v;
    logic        sh_pair;
    logic [15:0] mul_a;
    logic [15:0] mul_b;
    logic [31:0] mul_p;
    logic        is_mul;
    logic        is_shift;

    // Field bounds from constants or control operand
    assign set_start = req.cst_form ? req.csta
                                    : req.src1[SETF_START_LSB +: SETF_POS_W];
    assign set_end   = req.cst_form ? req.cstb
                                    : req.src1[SETF_END_LSB +: SETF_POS_W];

    // Per-bit field mask, position 0 at the LSB
    for (genvar gi = 0; gi < W_WORD; gi++) begin : g_mask
        assign set_mask[gi] = (5'(gi) >= set_start) && (5'(gi) <= set_end);
    end

    // Shift amount selection
    assign amt_reg = req.src1[5:0];
    always_comb begin
        if (req.opfield[OPF_REG_BIT]) begin
            amt = (amt_reg > SHAMT_MAX_VALID) ? SHAMT_LIMIT : amt_reg;
        end else begin
            amt = {1'b0, req.src1[4:0]};
        end
    end

    // Source extension for shifts
    assign src_word   = req.opfield[OPF_WORD_BIT];
    assign src_signed = (req.op == arith_right_shift_op) ||
                        ((req.op == arith_left_shift_op) && req.opfield[OPF_SIGNED_BIT]);
    assign src_x      = src_word ? {{8{src_signed & req.src2[31]}}, req.src2[31:0]} : req.src2;

    assign shl_v  = src_x << amt;
    assign shr_v  = 40'($signed(src_x) >>> amt);
    assign logical_right_shift_op_v = src_x >> amt;

    always_comb begin
        case (req.op)
            arith_left_shift_op:    sh_v = shl_v;
            arith_right_shift_op:   sh_v = shr_v;
            logical_right_shift_op: sh_v = logical_right_shift_op_v;
            default:                sh_v = src_x;
        endcase
    end

    // Long source shifts and unsigned word to long left shift write a pair
    assign sh_pair = !src_word ||
                     ((req.op == arith_left_shift_op) && !req.opfield[OPF_SIGNED_BIT]);

    // Fractional multiply operand halves
    assign is_mul = (req.op == frac_mul_low_low_op) || (req.op == frac_mul_high_high_op);
    assign is_shift = (req.op == arith_left_shift_op) || (req.op == arith_right_shift_op) ||
                      (req.op == logical_right_shift_op);
    assign mul_a = (req.op == frac_mul_high_high_op) ? req.src1[31:16] : req.src1[15:0];
    assign mul_b = (req.op == frac_mul_high_high_op) ? req.src2[31:16] : req.src2[15:0];
    assign mul_p = $signed({{16{mul_a[15]}}, mul_a}) * $signed({{16{mul_b[15]}}, mul_b});

    always_comb begin
        st_nxt = st_r;
        // Single-stage unit result
        st_nxt.s_res.valid   = req.valid && !is_mul;
        st_nxt.s_res.pair    = 1'b0;
        st_nxt.s_res.clamped = 1'b0;
        st_nxt.s_res.lo      = req.src2[31:0];
        st_nxt.s_res.hi      = '0;
        case (req.op)
            op_bit_set: begin
                st_nxt.s_res.lo = req.src2[31:0] | set_mask;
            end
            arith_left_shift_op, arith_right_shift_op, logical_right_shift_op: begin
                st_nxt.s_res.lo   = sh_v[31:0];
                st_nxt.s_res.pair = sh_pair;
                // Odd register holds bits 39:32 only, upper bits zero
                if (sh_pair) begin
                    st_nxt.s_res.hi = {24'h0, sh_v[39:32]};
                end
            end
            op_clamp_40_to_32: begin
                if ($signed(req.src2) > $signed(LONG_WORD_MAX)) begin
                    st_nxt.s_res.lo      = WORD_MAX;
                    st_nxt.s_res.clamped = 1'b1;
                end else if ($signed(req.src2) < $signed(LONG_WORD_MIN)) begin
                    st_nxt.s_res.lo      = WORD_MIN;
                    st_nxt.s_res.clamped = 1'b1;
                end
            end
            default: begin
                st_nxt.s_res.lo = req.src2[31:0];
            end
        endcase

        // Multiply first stage holds the shifted product
        st_nxt.m_valid = req.valid && is_mul;
        st_nxt.m_prod  = {mul_p[30:0], 1'b0};

        // Multiply second stage writes the destination
        st_nxt.m_res.valid   = st_r.m_valid;
        st_nxt.m_res.pair    = 1'b0;
        st_nxt.m_res.hi      = '0;
        st_nxt.m_res.clamped = (st_r.m_prod == FRAC_NEG_ONE);
        st_nxt.m_res.lo      = st_nxt.m_res.clamped ? WORD_MAX : st_r.m_prod;

        // Sticky flag; a clamp in the clear cycle wins
        st_nxt.saturation_flag = (st_r.s_res.valid && st_r.s_res.clamped) ||
                                 (st_r.m_res.valid && st_r.m_res.clamped) ||
                                 (st_r.saturation_flag && !flag_clear);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r                 <= '0;
            st_r.saturation_flag <= FLAG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_res           = st_r.s_res;
    assign m_res           = st_r.m_res;
    assign saturation_flag = st_r.saturation_flag;

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic issue_set;
    logic issue_shift_reg_long;
    logic issue_clamp_hi;
    assign issue_set = req.valid && (req.op == op_bit_set);
    assign issue_shift_reg_long = req.valid && is_shift && req.opfield[OPF_REG_BIT] &&
                                  !req.opfield[OPF_WORD_BIT] && (amt_reg > SHAMT_MAX_VALID);
    assign issue_clamp_hi = req.valid && (req.op == op_clamp_40_to_32) &&
                            ($signed(req.src2) > $signed(LONG_WORD_MAX));

    logic clamped_now;
    logic issue_clamp_lo;
    assign clamped_now = (s_res.valid && s_res.clamped) || (m_res.valid && m_res.clamped);
    assign issue_clamp_lo = req.valid && (req.op == op_clamp_40_to_32) &&
                            ($signed(req.src2) < $signed(LONG_WORD_MIN));

    sequence mul_issue_s;
        req.valid && is_mul && !$past(req.valid && is_mul);
    endsequence

    sequence mul_write_s;
        !m_res.valid ##1 m_res.valid;
    endsequence

    a_set_keeps_ones: assert property (
        issue_set |-> ##1 s_res.valid && ((s_res.lo & $past(req.src2[31:0])) ==
                                          $past(req.src2[31:0])))
        else $error("bit-field set cleared a source bit");

    a_set_end_bit: assert property (
        issue_set && !req.cst_form && (req.src1[4:0] >= req.src1[9:5])
        |-> ##1 s_res.lo[$past(req.src1[4:0])] && s_res.lo[$past(req.src1[9:5])])
        else $error("bit-field end or start bit not set");

    a_left_clamp_40: assert property (
        issue_shift_reg_long && (req.op == arith_left_shift_op)
        |-> ##1 (s_res.lo == '0) && (s_res.hi == '0))
        else $error("left shift above 39 did not shift by 40");

    a_right_clamp_40: assert property (
        issue_shift_reg_long && (req.op == arith_right_shift_op)
        |-> ##1 s_res.lo == {32{$past(req.src2[39])}})
        else $error("right shift above 39 did not fill with sign");

    a_lrs_clamp_40: assert property (
        issue_shift_reg_long && (req.op == logical_right_shift_op)
        |-> ##1 (s_res.lo == '0) && (s_res.hi == '0))
        else $error("logical right shift above 39 not zero");

    a_imm_shift_word: assert property (
        req.valid && (req.op == arith_left_shift_op) && !req.opfield[OPF_REG_BIT] &&
        req.opfield[OPF_WORD_BIT]
        |-> ##1 s_res.lo == ($past(req.src2[31:0]) << $past(req.src1[4:0])))
        else $error("immediate left shift result wrong");

    a_single_stage: assert property (
        req.valid && !is_mul |-> ##1 s_res.valid)
        else $error("single-stage result missing");

    a_mul_delay: assert property (
        mul_issue_s |-> ##1 mul_write_s)
        else $error("multiply result not after one delay slot");

    a_mul_clamp: assert property (
        req.valid && (req.op == frac_mul_low_low_op) &&
        (req.src1[15:0] == 16'h8000) && (req.src2[15:0] == 16'h8000)
        |-> ##2 m_res.valid && (m_res.lo == WORD_MAX))
        else $error("fractional product not clamped");

    a_flag_after_write: assert property (
        (m_res.valid && m_res.clamped) || (s_res.valid && s_res.clamped)
        |-> ##1 saturation_flag)
        else $error("flag not set one cycle after clamped write");

    a_long_clamp: assert property (
        issue_clamp_hi |-> ##1 s_res.clamped && (s_res.lo == WORD_MAX) ##1 saturation_flag)
        else $error("long-to-word clamp wrong");

    // Flag, clamp and result shape checks
    a_flag_holds: assert property (
        saturation_flag && !flag_clear |-> ##1 saturation_flag)
        else $error("saturation flag dropped without a clear");

    a_flag_clears: assert property (
        saturation_flag && flag_clear && !clamped_now |-> ##1 !saturation_flag)
        else $error("saturation flag not cleared");

    a_flag_set_wins: assert property (
        clamped_now && flag_clear |-> ##1 saturation_flag)
        else $error("clear beat a clamp in the same cycle");

    a_flag_no_spurious: assert property (
        !saturation_flag && !clamped_now |-> ##1 !saturation_flag)
        else $error("saturation flag set without a clamp");

    a_long_clamp_low: assert property (
        issue_clamp_lo |-> ##1 s_res.clamped && (s_res.lo == WORD_MIN))
        else $error("long-to-word low clamp wrong");

    a_set_empty_field: assert property (
        issue_set && (set_start > set_end) |-> ##1 s_res.lo == $past(req.src2[31:0]))
        else $error("bit-field set with empty field changed the source");

    a_single_no_mul: assert property (
        req.valid && is_mul |-> ##1 !s_res.valid)
        else $error("multiply raised a single-stage result");

    a_mul_word_only: assert property (
        m_res.valid |-> !m_res.pair && (m_res.hi == '0))
        else $error("multiply result not a single word");

    a_mul_high_clamp: assert property (
        req.valid && (req.op == frac_mul_high_high_op) &&
        (req.src1[31:16] == 16'h8000) && (req.src2[31:16] == 16'h8000)
        |-> ##2 m_res.valid && m_res.clamped && (m_res.lo == WORD_MAX))
        else $error("high-half product not clamped");

    a_pair_upper_zero: assert property (
        s_res.valid && s_res.pair |-> s_res.hi[31:8] == '0)
        else $error("register pair upper bits not zero");

    a_word_hi_zero: assert property (
        s_res.valid && !s_res.pair |-> s_res.hi == '0)
        else $error("single word result has odd register bits");

endmodule
`default_nettype wire

// *** verif/issue_model.sv ***
`default_nettype none
module issue_model
    import shift_bitfield_satmul_pkg::*;
(
    // Clock
    input  wire logic      core_clk,
    // Issue to unit
    output var  exec_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // One request per edge, held until the next edge
    task automatic issue(input exec_req_t r);
        @(posedge core_clk);
        if (r.op == op_bit_set && !r.cst_form) begin
            r.src1[31:10] = '0;
        end
        req <= r;
    endtask

    // Released bus shows the inverse of the last request
    task automatic idle();
        exec_req_t t;
        @(posedge core_clk);
        t = exec_req_t'(~req);
        t.valid = 1'b0;
        req <= t;
    endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`default_nettype none
module tb_top
    import shift_bitfield_satmul_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk   = 1'b0;
    logic        rst_n      = 1'b0;
    logic        flag_clear = 1'b0;
    logic        exp_flag   = 1'b0;
    logic        clamp_seen;
    logic [15:0] seed       = 16'hBA0D;
    exec_req_t   req;
    exec_res_t   s_res;
    exec_res_t   m_res;
    logic        saturation_flag;
    exec_res_t   sq[$];
    exec_res_t   mq[$];
    int          sd[$];
    int          md[$];
    int          cyc, compares, miscompares;

    always #10 core_clk = ~core_clk;

    issue_model u_issue (.core_clk(core_clk), .req(req));

    shift_bitfield_satmul_unit u_dut (.core_clk(core_clk), .rst_n(rst_n), .req(req),
        .flag_clear(flag_clear), .s_res(s_res), .m_res(m_res),
        .saturation_flag(saturation_flag));

    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction

    // Reference result of one request
    function automatic exec_res_t model(exec_req_t r);
        exec_res_t   e;
        logic [39:0] v;
        logic [31:0] p;
        logic        sg;
        int          a, s, t;
        e = '0;
        e.valid = 1'b1;
        sg = r.opfield[5] && r.op != logical_right_shift_op;
        a = r.opfield[0] ? r.src1[5:0] : r.src1[4:0];
        if (a > 39) a = 40;
        v = r.opfield[1] ? {{8{sg & r.src2[31]}}, r.src2[31:0]} : r.src2;
        case (r.op)
            op_bit_set: begin
                s = r.cst_form ? r.csta : r.src1[9:5];
                t = r.cst_form ? r.cstb : r.src1[4:0];
                e.lo = r.src2[31:0];
                for (int i = 0; i < 32; i++) begin
                    if (i >= s && i <= t) e.lo[i] = 1'b1;
                end
            end
            arith_left_shift_op: v = v << a;
            arith_right_shift_op: v = $signed(v) >>> a;
            logical_right_shift_op: v = v >> a;
            op_clamp_40_to_32: begin
                e.lo = r.src2[31:0];
                if ($signed(r.src2) > 40'sh007FFFFFFF || $signed(r.src2) < -40'sh0080000000) begin
                    e.lo = r.src2[39] ? 32'h80000000 : 32'h7FFFFFFF;
                    e.clamped = 1'b1;
                end
            end
            default: begin
                if (r.op == frac_mul_low_low_op) p = $signed(r.src1[15:0]) * $signed(r.src2[15:0]);
                else p = $signed(r.src1[31:16]) * $signed(r.src2[31:16]);
                e.lo = p << 1;
                if (e.lo == 32'h80000000) begin
                    e.lo = 32'h7FFFFFFF;
                    e.clamped = 1'b1;
                end
            end
        endcase
        if (r.op inside {arith_left_shift_op, arith_right_shift_op, logical_right_shift_op}) begin
            e.lo = v[31:0];
            e.pair = ~r.opfield[1] | ~r.opfield[5];
            if (e.pair) e.hi = {24'h0, v[39:32]};
        end
        return e;
    endfunction

    task automatic check_res(string n, exec_res_t x, exec_res_t g);
        compares++;
        if (g !== x) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic check_bit(string n, logic x, logic g);
        compares++;
        if (g !== x) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", n, x, g);
        end
    endtask

    task automatic watch(string n, ref exec_res_t q[$], ref int d[$], input exec_res_t g);
        exec_res_t e;
        e = '0;
        if (d.size() > 0 && d[0] == cyc) begin
            void'(d.pop_front());
            e = q.pop_front();
        end
        if (e.valid) check_res(n, e, g);
        else check_bit(n, 1'b0, g.valid);
        clamp_seen = clamp_seen | (e.valid & e.clamped);
    endtask

    // Scoreboard, sampled mid-cycle
    always @(negedge core_clk) begin
        cyc++;
        if (!rst_n) begin
            sq.delete();
            mq.delete();
            sd.delete();
            md.delete();
            exp_flag = 1'b0;
        end else begin
            clamp_seen = 1'b0;
            check_bit("flag", exp_flag, saturation_flag);
            watch("single", sq, sd, s_res);
            watch("mul", mq, md, m_res);
            exp_flag = clamp_seen | (exp_flag & ~flag_clear);
            if (req.valid === 1'b1) begin
                if (req.op inside {frac_mul_low_low_op, frac_mul_high_high_op}) begin
                    mq.push_back(model(req));
                    md.push_back(cyc + 2);
                end else begin
                    sq.push_back(model(req));
                    sd.push_back(cyc + 1);
                end
            end
        end
    end

    task automatic go(unit_op_t o, logic [5:0] f, logic c, logic [31:0] a, logic [39:0] b);
        exec_req_t r;
        r = '{valid: 1'b1, op: o, opfield: f, cst_form: c, csta: a[9:5], cstb: a[4:0],
              src1: c ? ~a : a, src2: b};
        u_issue.issue(r);
    endtask

    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        logic [15:0] t;
        logic [5:0]  f;
        unit_op_t    o;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        go(op_bit_set, 6'h00, 1'b1, 32'h000000F5, 40'h004B134A1E);
        go(op_bit_set, 6'h00, 1'b0, 32'hFFFFC197, 40'h009ED31A31);
        go(arith_left_shift_op, 6'h31, 1'b0, 32'hFFFFFFE7, 40'h09419751A5);
        go(arith_left_shift_op, 6'h13, 1'b0, 32'h0000003F, 40'h00F12363D1);
        go(arith_left_shift_op, 6'h31, 1'b0, 32'h00000022, 40'h09419751A5);
        go(arith_right_shift_op, 6'h35, 1'b0, 32'h00000028, 40'h921492A541);
        go(logical_right_shift_op, 6'h25, 1'b0, 32'hFFFFFFE9, 40'hF1F12363D1);
        go(frac_mul_high_high_op, 6'h00, 1'b0, 32'h80000000, 40'h0080000000);
        go(frac_mul_low_low_op, 6'h00, 1'b0, 32'h00008000, 40'h0000008000);
        go(op_clamp_40_to_32, 6'h00, 1'b0, 32'h0, 40'hFF80000000);
        go(op_clamp_40_to_32, 6'h00, 1'b0, 32'h0, 40'hFF7FFFFFFF);
        go(op_clamp_40_to_32, 6'h00, 1'b0, 32'h0, 40'h00A1907321);
        for (int k = 0; k < 600; k++) begin
            t = rnd();
            o = unit_op_t'(7'h01 << (t % 7));
            case (o)
                arith_left_shift_op: f = {t[5], 3'b100, t[1] | ~t[5], t[0]};
                arith_right_shift_op: f = {4'b1101, t[1:0]};
                default: f = {4'b1001, t[1:0]};
            endcase
            if (t[14:12] == 3'h0) u_issue.idle();
            else go(o, f, t[6], {rnd(), rnd()}, 40'({rnd(), rnd(), rnd()}));
            flag_clear <= (t[15:13] == 3'h7);
            if (k == 300) begin
                rst_n <= 1'b0;
                repeat (2) u_issue.idle();
                rst_n <= 1'b1;
            end
        end
        u_issue.idle();
        for (int k = 0; k < 5 && (sq.size() + mq.size()) > 0; k++) @(posedge core_clk);
        if ((sq.size() + mq.size()) > 0) miscompares++;
        results();
    end
endmodule
`default_nettype wire
